// *** hw/fsp_pkg.sv ***
package fsp_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LOCK = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int BIT_EN = 0;
   localparam int BIT_PAGE_ERASE_SELECT = 1;
   localparam int BIT_PAGE_WRITE_SELECT = 2;
   localparam int BIT_LOCK = 3;
   localparam int BIT_REEN = 4;
   localparam int BIT_SIG = 5;
   localparam int BIT_BUSY = 6;
   localparam int BIT_IE = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // Low six bits of a control write that mean a command
   localparam logic [5:0] PAT_LOAD = 6'h01;
   localparam logic [5:0] PAT_ERASE = 6'h03;
   localparam logic [5:0] PAT_WRITE = 6'h05;
   localparam logic [5:0] PAT_LOCK = 6'h09;
   localparam logic [5:0] PAT_REEN = 6'h11;
   localparam logic [5:0] PAT_SIG = 6'h21;

   // ****************************************************************
   // Pointer layout, page of 64 words
   // ****************************************************************
   localparam int WORD_LSB = 1;
   localparam int WORD_W = 6;
   localparam int PAGE_LSB = 7;
   localparam int PAGE_W = 7;
   localparam int BUF_WORDS = 64;
   localparam logic [PAGE_W-1:0] FIXED_PAGE_START = 7'h60;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;

   // ****************************************************************
   // Read-back sources and pointer values
   // ****************************************************************
   localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
   localparam logic [15:0] Z_LOCK = 16'h0001;
   localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
   localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
   localparam logic [15:0] Z_SIG1 = 16'h0000;
   localparam logic [15:0] Z_CAL = 16'h0001;
   localparam logic [15:0] Z_SIG2 = 16'h0002;
   localparam logic [15:0] Z_SIG3 = 16'h0004;
   localparam logic [7:0] FUSE_LOW_VAL = 8'h5E;
   localparam logic [7:0] FUSE_HIGH_VAL = 8'hD9;
   localparam logic [2:0] FUSE_EXT_VAL = 3'h4;
   // Identity bytes: arbitrary values
   localparam logic [7:0] SIG1_VAL = 8'h11;
   localparam logic [7:0] SIG2_VAL = 8'h22;
   localparam logic [7:0] SIG3_VAL = 8'h33;
   localparam logic [7:0] CAL_VAL = 8'h80;
   localparam logic [7:0] RESERVED_VAL = 8'hFF;
   localparam logic [3:0] LOCK_RST = 4'hF;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_TIME_MIN_NS = 3700000;
   localparam int PROG_TIME_MAX_NS = 4500000;
   localparam int PROG_CYCLES = (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 18;
   localparam logic [2:0] ARM_SPM_CYC = 3'h4;
   localparam logic [2:0] ARM_LPM_CYC = 3'h3;

   typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_BUSY} fsp_state_e;
   typedef enum logic [2:0] {CMD_NONE, CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_REEN, CMD_SIG} fsp_cmd_e;

endpackage : fsp_pkg

// *** hw/fsp_sequencer.sv ***
// Overview of operation
// R01: Software erases a page before writing it; buffer fill before or after erase.
// R02: Pattern X0000011 then store instruction within four cycles erases pointer's page.
// R03: Rewritable-section operation leaves fixed section readable; fixed-section target stalls CPU.
// R04: Pattern 00000001 plus store loads data pair at pointer's word index.
// R05: Buffer clears after page write, on read re-enable write, and at reset.
// R06: Software loads each buffer word at most once between clears.
// R07: EEPROM write during page loading discards all loaded buffer words.
// R08: Pattern X0000101 plus store writes buffer into pointer's page.
// R09: With interrupt enabled, request stays high while command enable is zero.
// R10: Erase or write blocks rewritable reads and holds busy flag meanwhile (here only for a rewritable-section target page).
// R11: Software re-enables rewritable section afterwards and keeps vectors off it.
// R12: Pattern X0001001 plus store programs boot lock bits from data bits 5..2.
// R13: Each zero data bit in 5..2 programs its lock bit; pointer ignored.
// R14: Software should use pointer 0x0001 and ones in data bits 7,6,1,0.
// R15: Lock programming leaves all flash readable, no stall, no blocking.
// R16: During EEPROM write all commands and lock/fuse reads are ignored.
// R17: Lock set plus enable, pointer 0x0001, load within three cycles returns locks.
// R18: Lock set and enable clear on read, three-cycle load or four-cycle store timeout.
// R19: Pointer 0x0000 low fuse, 0x0003 high fuse, 0x0002 extended fuse bits 2..0.
// R20: Programmed fuse or lock bits read zero, unprogrammed read one.
// R21: Signature read returns bytes at 0x0000, 0x0002, 0x0004, calibration at 0x0001.
// R22: Signature select and enable clear after read or three cycles idle.
// R23: Control bits 7..0: irq enable, busy, signature, re-enable, lock, write, erase, enable.
// R24: Command enable arms store for four cycles, stays set through erase/write.
// R25: Re-enable write aborts loading; refused while erase or write busy.
// R26: Erase, write and lock programming each take 3.7 ms to 4.5 ms.
// R27: Stall output holds from acceptance to completion of fixed-section erase/write.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module fsp_sequencer #(
   parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic store_prog_instr,
   input wire logic load_program_instr,
   input wire logic [15:0] zptr,
   input wire logic [7:0] data_low_reg,
   input wire logic [7:0] data_high_reg,
   input wire logic eeprom_write_busy,
   input wire logic [5:0] buf_rd_idx,
   output logic [15:0] buf_rd_data,
   output logic prog_erase,
   output logic prog_write,
   output logic prog_lock,
   output logic [6:0] prog_page,
   output logic lpm_data_valid,
   output logic [7:0] lpm_data,
   output logic cpu_stall,
   output logic rewritable_read_block,
   output logic prog_ready_irq,
   output logic [3:0] boot_lock_bits
);

   typedef struct packed {
      fsp_pkg::fsp_state_e st;
      fsp_pkg::fsp_cmd_e cmd;
      logic [7:0] ctrl;
      logic [2:0] arm_cnt;
      logic [fsp_pkg::CNT_W-1:0] busy_cnt;
      logic [6:0] page;
      logic to_fixed;
      logic [3:0] lock_pend;
      logic [3:0] lock_bits;
      logic [fsp_pkg::BUF_WORDS-1:0] buf_valid;
      logic [fsp_pkg::BUF_WORDS-1:0][15:0] mem;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [15:0] buf_rd_data;
      logic prog_erase;
      logic prog_write;
      logic prog_lock;
      logic lpm_valid;
      logic [7:0] lpm_data;
      logic stall;
      logic irq;
   } fsp_state_s;

   fsp_state_s q_r;
   fsp_state_s q_nxt;

   // ****************************************************************
   // Decoding helpers
   // ****************************************************************
   function automatic fsp_pkg::fsp_cmd_e cmd_of(input logic [5:0] low);
      unique case (low)
         fsp_pkg::PAT_LOAD: cmd_of = fsp_pkg::CMD_LOAD;
         fsp_pkg::PAT_ERASE: cmd_of = fsp_pkg::CMD_ERASE;
         fsp_pkg::PAT_WRITE: cmd_of = fsp_pkg::CMD_WRITE;
         fsp_pkg::PAT_LOCK: cmd_of = fsp_pkg::CMD_LOCK;
         fsp_pkg::PAT_REEN: cmd_of = fsp_pkg::CMD_REEN;
         fsp_pkg::PAT_SIG: cmd_of = fsp_pkg::CMD_SIG;
         default: cmd_of = fsp_pkg::CMD_NONE;
      endcase
   endfunction : cmd_of

   function automatic logic [7:0] fuse_lock_of(input logic [15:0] z, input logic [3:0] locks);
      // Programmed bits are zero, unprogrammed one
      if (z == fsp_pkg::Z_LOCK) begin
         fuse_lock_of = {2'h3, locks, 2'h3};
      end else if (z == fsp_pkg::Z_FUSE_LOW) begin
         fuse_lock_of = fsp_pkg::FUSE_LOW_VAL;
      end else if (z == fsp_pkg::Z_FUSE_HIGH) begin
         fuse_lock_of = fsp_pkg::FUSE_HIGH_VAL;
      end else if (z == fsp_pkg::Z_FUSE_EXT) begin
         fuse_lock_of = {5'h1F, fsp_pkg::FUSE_EXT_VAL};
      end else begin
         fuse_lock_of = fsp_pkg::RESERVED_VAL;
      end
   endfunction : fuse_lock_of

   function automatic logic [7:0] sig_of(input logic [15:0] z);
      if (z == fsp_pkg::Z_SIG1) begin
         sig_of = fsp_pkg::SIG1_VAL;
      end else if (z == fsp_pkg::Z_SIG2) begin
         sig_of = fsp_pkg::SIG2_VAL;
      end else if (z == fsp_pkg::Z_SIG3) begin
         sig_of = fsp_pkg::SIG3_VAL;
      end else if (z == fsp_pkg::Z_CAL) begin
         sig_of = fsp_pkg::CAL_VAL;
      end else begin
         sig_of = fsp_pkg::RESERVED_VAL;
      end
   endfunction : sig_of

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic setup_ph;
   logic ctrl_wr;
   logic spm_ok;
   logic lpm_ok;
   logic [5:0] widx;
   logic [6:0] pidx;
   fsp_pkg::fsp_cmd_e wr_cmd;

   always_comb begin
      q_nxt = q_r;
      setup_ph = psel && !penable;
      ctrl_wr = psel && penable && pwrite && (paddr == fsp_pkg::ADDR_CTRL);
      widx = zptr[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_W];
      pidx = zptr[fsp_pkg::PAGE_LSB +: fsp_pkg::PAGE_W];
      wr_cmd = cmd_of(pwdata[5:0]);
      // R16 eeprom blocks commands
      spm_ok = store_prog_instr && !eeprom_write_busy && (q_r.st == fsp_pkg::FSP_ARMED);
      lpm_ok = load_program_instr && !eeprom_write_busy && (q_r.st == fsp_pkg::FSP_ARMED)
         && (q_r.arm_cnt > (fsp_pkg::ARM_SPM_CYC - fsp_pkg::ARM_LPM_CYC));
      q_nxt.lpm_valid = 1'b0;
      q_nxt.pready = 1'b1;

      // APB answer prepared in setup phase, shown in access phase
      if (setup_ph) begin
         q_nxt.pslverr = 1'b0;
         unique case (paddr)
            fsp_pkg::ADDR_CTRL: q_nxt.prdata = {24'h0, q_r.ctrl};
            fsp_pkg::ADDR_LOCK: q_nxt.prdata = {24'h0, fuse_lock_of(fsp_pkg::Z_LOCK, q_r.lock_bits)};
            fsp_pkg::ADDR_STAT: q_nxt.prdata = {27'h0, q_r.to_fixed, |q_r.buf_valid, 1'b0, q_r.st};
            default: begin
               q_nxt.prdata = 32'h0;
               q_nxt.pslverr = 1'b1;
            end
         endcase
      end

      unique case (q_r.st)
         fsp_pkg::FSP_IDLE: begin
         end
         fsp_pkg::FSP_ARMED: begin
            // R18 four-cycle store window
            if (q_r.arm_cnt == 3'h1) begin
               q_nxt.st = fsp_pkg::FSP_IDLE;
               q_nxt.cmd = fsp_pkg::CMD_NONE;
               q_nxt.ctrl[5:0] = 6'h0;
            end else begin
               q_nxt.arm_cnt = q_r.arm_cnt - 3'h1;
            end
            // R22 signature window is three cycles
            if (q_r.cmd == fsp_pkg::CMD_SIG
                  && q_r.arm_cnt == (fsp_pkg::ARM_SPM_CYC - fsp_pkg::ARM_LPM_CYC + 3'h1)) begin
               q_nxt.st = fsp_pkg::FSP_IDLE;
               q_nxt.cmd = fsp_pkg::CMD_NONE;
               q_nxt.ctrl[5:0] = 6'h0;
            end
            if (spm_ok) begin
               q_nxt.ctrl[5:0] = 6'h0;
               q_nxt.st = fsp_pkg::FSP_IDLE;
               q_nxt.cmd = fsp_pkg::CMD_NONE;
               unique case (q_r.cmd)
                  fsp_pkg::CMD_LOAD: begin
                     // R04 word store into buffer
                     if (!q_r.buf_valid[widx]) begin
                        q_nxt.mem[widx] = {data_high_reg, data_low_reg};
                        q_nxt.buf_valid[widx] = 1'b1;
                     end
                     q_nxt.ctrl[fsp_pkg::BIT_BUSY] = 1'b0;
                  end
                  fsp_pkg::CMD_ERASE, fsp_pkg::CMD_WRITE: begin
                     // R02 R08 start timed page operation
                     q_nxt.st = fsp_pkg::FSP_BUSY;
                     q_nxt.cmd = q_r.cmd;
                     q_nxt.ctrl[5:0] = q_r.ctrl[5:0];
                     q_nxt.busy_cnt = fsp_pkg::CNT_W'(PROG_CYCLES - 1);
                     q_nxt.page = pidx;
                     q_nxt.to_fixed = (pidx >= fsp_pkg::FIXED_PAGE_START);
                     q_nxt.prog_erase = (q_r.cmd == fsp_pkg::CMD_ERASE);
                     q_nxt.prog_write = (q_r.cmd == fsp_pkg::CMD_WRITE);
                     // R03 R27 stall only for fixed-section target
                     q_nxt.stall = (pidx >= fsp_pkg::FIXED_PAGE_START);
                     // R10 block rewritable reads
                     q_nxt.ctrl[fsp_pkg::BIT_BUSY] = (pidx < fsp_pkg::FIXED_PAGE_START);
                  end
                  fsp_pkg::CMD_LOCK: begin
                     // R12 R13 R15 lock programming, no stall or block
                     q_nxt.st = fsp_pkg::FSP_BUSY;
                     q_nxt.cmd = q_r.cmd;
                     q_nxt.ctrl[5:0] = q_r.ctrl[5:0];
                     q_nxt.busy_cnt = fsp_pkg::CNT_W'(PROG_CYCLES - 1);
                     q_nxt.lock_pend = data_low_reg[5:2];
                     q_nxt.prog_lock = 1'b1;
                  end
                  fsp_pkg::CMD_REEN: begin
                     q_nxt.ctrl[fsp_pkg::BIT_BUSY] = 1'b0;
                  end
                  default: begin
                     // Store during signature read has no effect
                     q_nxt.st = q_nxt.st;
                  end
               endcase
               if (q_r.cmd == fsp_pkg::CMD_SIG
                     && q_r.arm_cnt > (fsp_pkg::ARM_SPM_CYC - fsp_pkg::ARM_LPM_CYC + 3'h1)) begin
                  q_nxt.st = q_r.st;
                  q_nxt.cmd = q_r.cmd;
                  q_nxt.ctrl[5:0] = q_r.ctrl[5:0];
                  q_nxt.arm_cnt = q_r.arm_cnt - 3'h1;
               end
            end else if (lpm_ok && (q_r.cmd == fsp_pkg::CMD_LOCK || q_r.cmd == fsp_pkg::CMD_SIG)) begin
               // R17 R19 R20 R21 timed read-back
               q_nxt.lpm_valid = 1'b1;
               q_nxt.lpm_data = (q_r.cmd == fsp_pkg::CMD_LOCK) ? fuse_lock_of(zptr, q_r.lock_bits) : sig_of(zptr);
               // R18 R22 clear after read
               q_nxt.st = fsp_pkg::FSP_IDLE;
               q_nxt.cmd = fsp_pkg::CMD_NONE;
               q_nxt.ctrl[5:0] = 6'h0;
            end
         end
         fsp_pkg::FSP_BUSY: begin
            // R26 operation time
            if (q_r.busy_cnt == '0) begin
               // R24 enable drops only at completion
               q_nxt.st = fsp_pkg::FSP_IDLE;
               q_nxt.cmd = fsp_pkg::CMD_NONE;
               q_nxt.ctrl[5:0] = 6'h0;
               q_nxt.prog_erase = 1'b0;
               q_nxt.prog_write = 1'b0;
               q_nxt.prog_lock = 1'b0;
               q_nxt.stall = 1'b0;
               // R05 buffer clears after page write
               if (q_r.cmd == fsp_pkg::CMD_WRITE) begin
                  q_nxt.buf_valid = '0;
               end
               // R13 zero data bit programs lock bit
               if (q_r.cmd == fsp_pkg::CMD_LOCK) begin
                  q_nxt.lock_bits = q_r.lock_bits & q_r.lock_pend;
               end
            end else begin
               q_nxt.busy_cnt = q_r.busy_cnt - fsp_pkg::CNT_W'(1);
            end
         end
         default: begin
            q_nxt.st = fsp_pkg::FSP_IDLE;
         end
      endcase

      // R23 control write; R25 refused while busy, enable only
      if (ctrl_wr) begin
         q_nxt.ctrl[fsp_pkg::BIT_IE] = pwdata[fsp_pkg::BIT_IE];
         if (q_r.st != fsp_pkg::FSP_BUSY && !eeprom_write_busy && wr_cmd != fsp_pkg::CMD_NONE) begin
            q_nxt.ctrl[5:0] = pwdata[5:0];
            q_nxt.cmd = wr_cmd;
            q_nxt.st = fsp_pkg::FSP_ARMED;
            // R24 arm for four cycles
            q_nxt.arm_cnt = fsp_pkg::ARM_SPM_CYC;
            // R05 R25 re-enable write clears buffer
            if (wr_cmd == fsp_pkg::CMD_REEN) begin
               q_nxt.buf_valid = '0;
            end
         end
      end

      // R07 EEPROM write discards loaded words
      if (eeprom_write_busy && |q_r.buf_valid) begin
         q_nxt.buf_valid = '0;
      end

      q_nxt.buf_rd_data = q_r.buf_valid[buf_rd_idx] ? q_r.mem[buf_rd_idx] : fsp_pkg::ERASED_WORD;
      // R09 level interrupt while enable is low
      q_nxt.irq = q_nxt.ctrl[fsp_pkg::BIT_IE] && !q_nxt.ctrl[fsp_pkg::BIT_EN];
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r.st <= fsp_pkg::FSP_IDLE;
         q_r.cmd <= fsp_pkg::CMD_NONE;
         q_r.ctrl <= fsp_pkg::CTRL_RST;
         q_r.arm_cnt <= 3'h0;
         q_r.busy_cnt <= '0;
         q_r.page <= 7'h00;
         q_r.to_fixed <= 1'b0;
         q_r.lock_pend <= fsp_pkg::LOCK_RST;
         q_r.lock_bits <= fsp_pkg::LOCK_RST;
         // R05 reset clears buffer
         q_r.buf_valid <= '0;
         q_r.mem <= '1;
         q_r.prdata <= 32'h0;
         q_r.pready <= 1'b0;
         q_r.pslverr <= 1'b0;
         q_r.buf_rd_data <= fsp_pkg::ERASED_WORD;
         q_r.prog_erase <= 1'b0;
         q_r.prog_write <= 1'b0;
         q_r.prog_lock <= 1'b0;
         q_r.lpm_valid <= 1'b0;
         q_r.lpm_data <= 8'h00;
         q_r.stall <= 1'b0;
         q_r.irq <= 1'b0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign prdata = q_r.prdata;
   assign pready = q_r.pready;
   assign pslverr = q_r.pslverr;
   assign buf_rd_data = q_r.buf_rd_data;
   assign prog_erase = q_r.prog_erase;
   assign prog_write = q_r.prog_write;
   assign prog_lock = q_r.prog_lock;
   assign prog_page = q_r.page;
   assign lpm_data_valid = q_r.lpm_valid;
   assign lpm_data = q_r.lpm_data;
   assign cpu_stall = q_r.stall;
   assign rewritable_read_block = q_r.ctrl[fsp_pkg::BIT_BUSY];
   assign prog_ready_irq = q_r.irq;
   assign boot_lock_bits = q_r.lock_bits;

endmodule : fsp_sequencer

`default_nettype wire

// *** tb/fsp_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module fsp_cpu_model (
   input wire logic pclk,
   output logic store_prog_instr,
   output logic load_program_instr,
   output logic [15:0] zptr,
   output logic [7:0] data_low_reg,
   output logic [7:0] data_high_reg,
   output logic eeprom_write_busy
);
   initial begin
      store_prog_instr = 1'b0;
      load_program_instr = 1'b0;
      zptr = 16'h0000;
      data_low_reg = 8'h00;
      data_high_reg = 8'h00;
      eeprom_write_busy = 1'b0;
   end

   task automatic spm(input logic [15:0] z, input logic [15:0] d);
      @(posedge pclk);
      store_prog_instr <= 1'b1;
      zptr <= z;
      {data_high_reg, data_low_reg} <= d;
      @(posedge pclk);
      store_prog_instr <= 1'b0;
      zptr <= ~z;
      {data_high_reg, data_low_reg} <= ~d;
   endtask : spm

   task automatic lpm(input logic [15:0] z);
      @(posedge pclk);
      load_program_instr <= 1'b1;
      zptr <= z;
      @(posedge pclk);
      load_program_instr <= 1'b0;
      zptr <= ~z;
   endtask : lpm

   task automatic ee(input logic b);
      @(posedge pclk);
      eeprom_write_busy <= b;
   endtask : ee
endmodule : fsp_cpu_model

`default_nettype wire

// *** tb/fsp_seq_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module fsp_seq_monitor #(
   parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic store_prog_instr,
   input wire logic load_program_instr,
   input wire logic eeprom_write_busy,
   input wire logic prog_erase,
   input wire logic prog_write,
   input wire logic prog_lock,
   input wire logic [6:0] prog_page,
   input wire logic lpm_data_valid,
   input wire logic cpu_stall,
   input wire logic rewritable_read_block,
   input wire logic prog_ready_irq
);
   // ****************************************************************
   // Operation length counter
   // ****************************************************************
   wire logic op = prog_erase | prog_write | prog_lock;
   wire logic flash_op = prog_erase | prog_write;
   wire logic fixed_pg = prog_page >= fsp_pkg::FIXED_PAGE_START;
   int unsigned cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 0;
      end else begin
         cnt_r <= op ? cnt_r + 1 : 0;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_op_start;
      !op ##1 op;
   endsequence

   // ****************************************************************
   // Properties
   // ****************************************************************
   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data above bit 7 not zero");
   a_start_by_store: assert property (s_op_start |-> $past(store_prog_instr))
      else $error("operation began without store pulse");
   a_eeprom_blocks: assert property (s_op_start |-> !$past(eeprom_write_busy))
      else $error("operation began during eeprom write");
   a_read_answer: assert property (lpm_data_valid |-> $past(load_program_instr) && !$past(eeprom_write_busy))
      else $error("read data without a load pulse");
   a_irq_quiet: assert property (flash_op |-> !prog_ready_irq)
      else $error("ready request while busy");
   a_rww_block: assert property (flash_op && !fixed_pg |-> rewritable_read_block && !cpu_stall)
      else $error("rewritable section not blocked");
   a_stall_fixed: assert property (cpu_stall == (flash_op && fixed_pg))
      else $error("stall does not match fixed section work");
   a_lock_free: assert property (prog_lock |-> !cpu_stall && !flash_op)
      else $error("lock programming stalls or overlaps");
   a_op_length: assert property ($fell(op) |-> cnt_r >= PROG_CYCLES && cnt_r <= PROG_CYCLES + 1)
      else $error("operation length wrong");
endmodule : fsp_seq_monitor

bind fsp_sequencer fsp_seq_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_fsp_seq_monitor (.pclk, .presetn, .psel,
   .penable, .pwrite, .prdata, .pready, .store_prog_instr, .load_program_instr, .eeprom_write_busy, .prog_erase,
   .prog_write, .prog_lock, .prog_page, .lpm_data_valid, .cpu_stall, .rewritable_read_block, .prog_ready_irq);

`default_nettype wire

// *** tb/fsp_sequencer_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module fsp_sequencer_test;
   localparam logic [7:0] CT = fsp_pkg::ADDR_CTRL;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [5:0] buf_rd_idx = 6'h00;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, store_prog_instr, load_program_instr, eeprom_write_busy, prog_erase, prog_write;
   logic prog_lock, lpm_data_valid, cpu_stall, rewritable_read_block, prog_ready_irq;
   logic [15:0] zptr, buf_rd_data;
   logic [7:0] data_low_reg, data_high_reg, lpm_data;
   logic [6:0] prog_page;
   logic [3:0] boot_lock_bits;
   logic [15:0] zt [8] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h0, 16'h1, 16'h2, 16'h4};
   logic [7:0] et [8] = '{fsp_pkg::FUSE_LOW_VAL, 8'hD7, {5'h0, fsp_pkg::FUSE_EXT_VAL}, fsp_pkg::FUSE_HIGH_VAL,
      fsp_pkg::SIG1_VAL, fsp_pkg::CAL_VAL, fsp_pkg::SIG2_VAL, fsp_pkg::SIG3_VAL};
   int err_count = 0;
   int check_count = 0;

   always #12.5 pclk = ~pclk;

   fsp_sequencer #(.PROG_CYCLES(20)) u_fsp_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .store_prog_instr, .load_program_instr, .zptr, .data_low_reg, .data_high_reg,
      .eeprom_write_busy, .buf_rd_idx, .buf_rd_data, .prog_erase, .prog_write, .prog_lock, .prog_page,
      .lpm_data_valid, .lpm_data, .cpu_stall, .rewritable_read_block, .prog_ready_irq, .boot_lock_bits);
   fsp_cpu_model u_fsp_cpu_model (.pclk, .store_prog_instr, .load_program_instr, .zptr, .data_low_reg,
      .data_high_reg, .eeprom_write_busy);

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : cyc

   task automatic bufchk(input logic [5:0] i, input logic [15:0] exp);
      @(posedge pclk);
      buf_rd_idx <= i;
      cyc(1);
      check(buf_rd_data, exp);
   endtask : bufchk

   task automatic op_done();
      int n;
      n = 0;
      while ((prog_erase | prog_write | prog_lock) && n < 100) begin
         cyc(1);
         n++;
      end
      check(n < 100, 1'b1);
      cyc(1);
   endtask : op_done

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out

   initial begin
      repeat (4000) @(posedge pclk);
      err_count++;
      close_out();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, CT, 0); check(rd, 32'h0);
      apb(0, fsp_pkg::ADDR_LOCK, 0); check(rd, 32'hFF);
      apb(0, 8'h0C, 0); check(er, 1'b1);
      apb(1, CT, 1); u_fsp_cpu_model.spm(16'h000A, 16'h1234);
      apb(1, CT, 1); u_fsp_cpu_model.spm(16'h000A, 16'hABCD);
      bufchk(5, 16'h1234);
      apb(0, fsp_pkg::ADDR_STAT, 0); check(rd, 32'h8);
      apb(1, CT, 32'h83); u_fsp_cpu_model.spm(16'h0180, 16'h0);
      #1 check({prog_erase, prog_page, rewritable_read_block, cpu_stall}, 10'h20E);
      apb(0, CT, 0); check({rd[7:0], prog_ready_irq}, 9'h186);
      op_done();
      apb(0, CT, 0); check({rd[7:0], prog_ready_irq}, 9'h181);
      bufchk(5, 16'h1234);
      apb(1, CT, 32'h11); u_fsp_cpu_model.spm(16'h0, 16'h0);
      cyc(1); check(rewritable_read_block, 1'b0);
      bufchk(5, 16'hFFFF);
      apb(1, CT, 1); u_fsp_cpu_model.spm(16'h0004, 16'h5A5A);
      bufchk(2, 16'h5A5A);
      apb(1, CT, 5); u_fsp_cpu_model.spm(16'h3080, 16'h0);
      #1 check({prog_write, prog_page, cpu_stall}, 9'h1C3);
      apb(0, fsp_pkg::ADDR_STAT, 0); check(rd, 32'h1A);
      op_done(); check(cpu_stall, 1'b0);
      bufchk(2, 16'hFFFF);
      apb(1, CT, 9); u_fsp_cpu_model.spm(16'h0001, 16'h00D7);
      #1 check(prog_lock, 1'b1);
      op_done(); check(boot_lock_bits, 4'h5);
      apb(0, fsp_pkg::ADDR_LOCK, 0); check(rd, 32'hD7);
      for (int i = 0; i < 8; i++) begin
         apb(1, CT, i < 4 ? 32'h09 : 32'h21);
         u_fsp_cpu_model.lpm(zt[i]);
         #1 check(lpm_data_valid, 1'b1);
         check(lpm_data & (i == 2 ? 8'h07 : 8'hFF), et[i]);
         cyc(1); apb(0, CT, 0); check(rd[0], 1'b0);
      end
      apb(1, CT, 1); cyc(6); apb(0, CT, 0); check(rd[0], 1'b0);
      u_fsp_cpu_model.spm(16'h000C, 16'h6666); bufchk(6, 16'hFFFF);
      apb(1, CT, 1); u_fsp_cpu_model.spm(16'h000E, 16'h7777); bufchk(7, 16'h7777);
      u_fsp_cpu_model.ee(1'b1); bufchk(7, 16'hFFFF);
      apb(1, CT, 3); u_fsp_cpu_model.spm(16'h0, 16'h0);
      cyc(2); check(prog_erase, 1'b0);
      u_fsp_cpu_model.ee(1'b0);
      close_out();
   end
endmodule : fsp_sequencer_test

`default_nettype wire
